// ### verilog/cvc_pkg.sv
`default_nettype none
package cvc_pkg;
    // register byte offsets on the slave bus
    localparam logic [4:0] OFS_CLOCK   = 5'h00;
    localparam logic [4:0] OFS_PINS    = 5'h04;
    localparam logic [4:0] OFS_START   = 5'h08;
    localparam logic [4:0] OFS_RESULT  = 5'h0C;
    localparam logic [4:0] OFS_STATUS  = 5'h10;
    localparam logic [4:0] OFS_MASK    = 5'h14;
    localparam logic [4:0] OFS_PRIO    = 5'h18;
    localparam logic [4:0] OFS_VECTOR  = 5'h1C;
    // field positions
    localparam int CLK_SEL_LSB  = 0;
    localparam int CLK_GATE_BIT = 3;
    localparam int PIN_SEL_LSB  = 4;
    localparam int CHAN_LSB     = 0;
    localparam int START_BIT    = 7;
    localparam int DONE_BIT     = 0;
    // widths and reset values
    localparam int RES_W  = 10;
    localparam int SEL_W  = 3;
    localparam int CNT_W  = 6;
    localparam logic [2:0] CLK_SEL_RST  = 3'h0;
    localparam logic [2:0] SEL_LOW_OSC  = 3'h7;
    localparam logic [3:0] PIN_SEL_RST  = 4'h0;
    localparam logic [1:0] CHAN_RST     = 2'h0;
    localparam logic [1:0] PRIO_RST     = 2'h0;
    localparam logic [23:0] IRQ_VECTOR  = 24'h00_0024;
    // converter timing, counted in conversion-clock ticks / system cycles
    localparam logic [2:0] SAMPLE_DELAY_TICKS = 3'h4;
    localparam logic [2:0] SETTLE_CYCLES      = 3'h3;
    localparam logic [3:0] MSB_IDX            = 4'h9;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_DELAY  = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_CONV   = 4'b1000
    } cvc_state_t;
endpackage : cvc_pkg
`default_nettype wire

// ### verilog/cvc_conv_if.sv
`default_nettype none
interface cvc_conv_if;
    import cvc_pkg::*;
    logic [SEL_W-1:0] div_sel;
    logic             gate;
    logic             low_osc;
    logic             conv_tick;
    logic             start;
    logic [1:0]       chan;
    logic             comp;
    logic             sample_hold;
    logic [RES_W-1:0] dac_code;
    logic [1:0]       chan_latched;
    logic             done;
    logic [RES_W-1:0] result;
    logic             busy;
    modport div (input div_sel, gate, low_osc, output conv_tick);
    modport sar (input conv_tick, start, chan, comp,
                 output sample_hold, dac_code, chan_latched, done, result, busy);
    modport ctl (output div_sel, gate, low_osc, start, chan, comp,
                 input conv_tick, sample_hold, dac_code, chan_latched, done, result, busy);
endinterface : cvc_conv_if
`default_nettype wire

// ### verilog/cvc_clkdiv.sv
`default_nettype none
module cvc_clkdiv
    import cvc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // divider link
    cvc_conv_if.div   dv
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             low_prev;
        logic             tick;
    } cvc_div_t;
    cvc_div_t s_q, s_d;
    logic [CNT_W-1:0] mask;

    always_comb begin
        mask = CNT_W'((7'h01 << dv.div_sel) - 7'h01);
        s_d = s_q;
        s_d.low_prev = dv.low_osc;
        s_d.tick = 1'b0;
        if (!dv.gate) begin
            s_d.cnt = '0; // gated off: no ticks reach the converter
        end else if (dv.div_sel == SEL_LOW_OSC) begin
            s_d.tick = dv.low_osc & ~s_q.low_prev; // low-speed oscillator undivided
        end else begin
            s_d.tick = ((s_q.cnt & mask) == mask); // high-speed divided by 2^sel
            s_d.cnt  = CNT_W'(s_q.cnt + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
    assign dv.conv_tick = s_q.tick;
endmodule : cvc_clkdiv
`default_nettype wire

// ### verilog/cvc_sar.sv
`default_nettype none
module cvc_sar
    import cvc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // converter link
    cvc_conv_if.sar   sr
);
    typedef struct packed {
        cvc_state_t       st;
        logic [2:0]       dcnt;
        logic [2:0]       settle;
        logic [3:0]       idx;
        logic [RES_W-1:0] code;
        logic [1:0]       chan;
        logic             sample;
        logic             done;
        logic [RES_W-1:0] result;
    } cvc_sar_t;
    cvc_sar_t s_q, s_d;
    logic [RES_W-1:0] kept;

    always_comb begin
        s_d  = s_q;
        kept = s_q.code;
        s_d.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (sr.start) begin
                    s_d.chan = sr.chan; // channel latched at start
                    s_d.dcnt = '0;
                    s_d.st   = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (sr.conv_tick) begin
                    if (s_q.dcnt == SAMPLE_DELAY_TICKS - 3'h1) begin
                        s_d.sample = 1'b1; // sampling delay over
                        s_d.st     = ST_SAMPLE;
                    end else begin
                        s_d.dcnt = s_q.dcnt + 3'h1;
                    end
                end
            end
            ST_SAMPLE: begin
                if (sr.conv_tick) begin
                    s_d.sample = 1'b0; // hold from here on
                    s_d.idx    = MSB_IDX;
                    s_d.code   = RES_W'(1) << MSB_IDX;
                    s_d.settle = '0;
                    s_d.st     = ST_CONV;
                end
            end
            ST_CONV: begin
                if (s_q.settle != SETTLE_CYCLES) begin
                    s_d.settle = s_q.settle + 3'h1;
                end else if (sr.conv_tick) begin
                    // comparator high means input at or above the trial code
                    if (!sr.comp) begin
                        kept[s_q.idx] = 1'b0;
                    end
                    s_d.settle = '0;
                    if (s_q.idx == 4'h0) begin
                        s_d.code   = kept;
                        s_d.result = kept;
                        s_d.done   = 1'b1;
                        s_d.st     = ST_IDLE;
                    end else begin
                        kept[s_q.idx - 4'h1] = 1'b1;
                        s_d.code = kept; // successive approximation
                        s_d.idx  = s_q.idx - 4'h1;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q    <= '0;
            s_q.st <= ST_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
    assign sr.sample_hold  = s_q.sample;
    assign sr.dac_code     = s_q.code;
    assign sr.chan_latched = s_q.chan;
    assign sr.done         = s_q.done;
    assign sr.result       = s_q.result;
    assign sr.busy         = (s_q.st != ST_IDLE);
endmodule : cvc_sar
`default_nettype wire

// ### verilog/cvc_top.sv
// Design decisions made here: the Avalon-MM register port and the register addresses.
`default_nettype none
module cvc_top
    import cvc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // oscillator and cpu level
    input  wire logic        low_speed_osc,
    input  wire logic        cpu_irq_mask_bit0,
    input  wire logic        cpu_irq_mask_bit1,
    // analog front end
    input  wire logic        comparator_in,
    output logic             analog_pin_select_4,
    output logic             analog_pin_select_5,
    output logic             analog_pin_select_6,
    output logic             analog_pin_select_7,
    output logic [3:0]       input_route,
    output logic             sample_hold,
    output logic [9:0]       dac_code,
    output logic             conv_clock_active,
    output logic             conv_busy,
    // interrupt
    output logic             irq,
    output logic [23:0]      irq_vector
);
    typedef struct packed {
        logic             wait_b;
        logic [31:0]      rdata;
        logic [SEL_W-1:0] div_sel;
        logic             gate;
        logic [3:0]       pins;
        logic [1:0]       chan;
        logic             start;
        logic [RES_W-1:0] result;
        logic             done;
        logic             irq_en;
        logic [1:0]       prio;
        logic             irq;
        logic [23:0]      vec;
        logic             comp_s1;
        logic             comp_s2;
        logic             osc_s1;
        logic             osc_s2;
        logic [3:0]       route;
        logic             sample;
        logic [RES_W-1:0] dac;
        logic             clk_act;
        logic             busy;
    } cvc_top_t;

    cvc_top_t s_q, s_d;
    cvc_conv_if cif ();

    logic       req;
    logic       accept;
    logic       wr_lane0;
    logic [1:0] cpu_level;
    logic       done_set;
    logic       done_clr;

    // one-hot route select from the latched channel code
    function automatic logic [3:0] chan_onehot(input logic [1:0] c);
        logic [3:0] r;
        r = 4'h0;
        r[c] = 1'b1;
        return r;
    endfunction : chan_onehot

    assign cif.div_sel = s_q.div_sel;
    assign cif.gate    = s_q.gate;
    assign cif.low_osc = s_q.osc_s2;
    assign cif.start   = s_q.start;
    assign cif.chan    = s_q.chan;
    assign cif.comp    = s_q.comp_s2;

    cvc_clkdiv u_div (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .dv    (cif.div)
    );

    cvc_sar u_sar (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .sr    (cif.sar)
    );

    always_comb begin
        req       = avs_read | avs_write;
        // wait_b high means waitrequest is low this cycle: the transfer completes now
        accept    = req & s_q.wait_b;
        wr_lane0  = accept & avs_write & avs_byteenable[0];
        cpu_level = {cpu_irq_mask_bit1, cpu_irq_mask_bit0};
        done_set  = cif.done;
        done_clr  = wr_lane0 && (avs_address == OFS_STATUS)
                    && avs_writedata[DONE_BIT];

        s_d = s_q;

        // pin synchronisers: the first stage feeds only the second
        s_d.comp_s1 = comparator_in;
        s_d.comp_s2 = s_q.comp_s1;
        s_d.osc_s1  = low_speed_osc;
        s_d.osc_s2  = s_q.osc_s1;

        s_d.start  = 1'b0;
        s_d.wait_b = 1'b0;
        s_d.rdata  = '0;

        // bus slave: one wait cycle, then a single completing cycle
        if (req && !s_q.wait_b) begin
            s_d.wait_b = 1'b1;
            if (avs_read) begin
                case (avs_address)
                    OFS_CLOCK: begin
                        s_d.rdata[CLK_SEL_LSB +: SEL_W] = s_q.div_sel;
                        s_d.rdata[CLK_GATE_BIT]         = s_q.gate;
                    end
                    OFS_PINS: begin
                        s_d.rdata[PIN_SEL_LSB +: 4] = s_q.pins;
                    end
                    OFS_START: begin
                        // start bit is not stored and reads as zero
                        s_d.rdata[CHAN_LSB +: 2] = s_q.chan;
                    end
                    OFS_RESULT: begin
                        s_d.rdata[RES_W-1:0] = s_q.result; // bit 0 is the lsb
                    end
                    OFS_STATUS: begin
                        s_d.rdata[DONE_BIT] = s_q.done;
                    end
                    OFS_MASK: begin
                        s_d.rdata[DONE_BIT] = s_q.irq_en;
                    end
                    OFS_PRIO: begin
                        s_d.rdata[1:0] = s_q.prio;
                    end
                    OFS_VECTOR: begin
                        s_d.rdata[23:0] = s_q.vec;
                    end
                    default: begin
                        s_d.rdata = '0;
                    end
                endcase
            end
        end

        if (wr_lane0) begin
            case (avs_address)
                OFS_CLOCK: begin
                    // reselecting mid conversion is left to software
                    s_d.div_sel = avs_writedata[CLK_SEL_LSB +: SEL_W];
                    s_d.gate    = avs_writedata[CLK_GATE_BIT];
                end
                OFS_PINS: begin
                    s_d.pins = avs_writedata[PIN_SEL_LSB +: 4];
                end
                OFS_START: begin
                    s_d.chan = avs_writedata[CHAN_LSB +: 2];
                    // a 0 does nothing; a start while busy is dropped
                    s_d.start = avs_writedata[START_BIT] & ~cif.busy;
                end
                OFS_MASK: begin
                    s_d.irq_en = avs_writedata[DONE_BIT];
                end
                OFS_PRIO: begin
                    s_d.prio = avs_writedata[1:0];
                end
                default: begin
                    s_d.vec = s_q.vec;
                end
            endcase
        end

        // the result register only changes when a conversion finishes
        if (done_set) begin
            s_d.result = cif.result;
        end

        // a completion in the same cycle as a clear keeps the flag set
        if (done_set) begin
            s_d.done = 1'b1;
        end else if (done_clr) begin
            s_d.done = 1'b0;
        end

        // level interrupt gated by enable and priority over the cpu level
        s_d.irq = s_q.done & s_q.irq_en & (s_q.prio > cpu_level);
        s_d.vec = IRQ_VECTOR;

        s_d.route   = chan_onehot(cif.chan_latched);
        s_d.sample  = cif.sample_hold;
        s_d.dac     = cif.dac_code;
        s_d.clk_act = cif.conv_tick;
        s_d.busy    = cif.busy;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q         <= '0;
            s_q.div_sel <= CLK_SEL_RST;
            s_q.pins    <= PIN_SEL_RST; // all shared pins digital
            s_q.chan    <= CHAN_RST;
            s_q.prio    <= PRIO_RST;
            s_q.vec     <= IRQ_VECTOR;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign avs_readdata        = s_q.rdata;
    assign avs_waitrequest     = ~s_q.wait_b;
    assign analog_pin_select_4 = s_q.pins[0];
    assign analog_pin_select_5 = s_q.pins[1];
    assign analog_pin_select_6 = s_q.pins[2];
    assign analog_pin_select_7 = s_q.pins[3];
    assign input_route         = s_q.route;
    assign sample_hold         = s_q.sample;
    assign dac_code            = s_q.dac;
    assign conv_clock_active   = s_q.clk_act;
    assign conv_busy           = s_q.busy;
    assign irq                 = s_q.irq;
    assign irq_vector          = s_q.vec;
endmodule : cvc_top
`default_nettype wire

// ### bench/cvc_analog_src.sv
`default_nettype none
module cvc_analog_src
    import cvc_pkg::*;
(
    // clock and bench control
    input  wire logic             clk,
    input  wire logic             slow,
    input  wire logic [RES_W-1:0] lvl [4],
    // converter front end
    input  wire logic [3:0]       pin_analog,
    input  wire logic [3:0]       input_route,
    input  wire logic             sample_hold,
    input  wire logic [RES_W-1:0] dac_code,
    output logic                  comparator_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [RES_W-1:0] held = '0;
    logic             cmp;
    logic             cmp_q = 1'b0;
    logic             junk = 1'b0;
    // the hold node keeps the last sample between phases
    always_ff @(posedge clk) begin
        junk <= !junk;
        cmp_q <= cmp;
        if (sample_hold) begin
            for (int i = 0; i < 4; i++)
                if (input_route[i]) held <= pin_analog[i] ? lvl[i] : {RES_W{junk}};
        end
    end
    assign cmp = held >= dac_code;
    // nothing routed: the comparator sees a floating node
    assign comparator_in = (input_route == 4'h0) ? junk : (slow ? cmp_q : cmp);
endmodule : cvc_analog_src
`default_nettype wire

// ### bench/cvc_chk.sv
`default_nettype none
module cvc_chk
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    // bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // device side
    input wire logic        cpu_irq_mask_bit0,
    input wire logic        cpu_irq_mask_bit1,
    input wire logic        analog_pin_select_4,
    input wire logic        analog_pin_select_5,
    input wire logic        analog_pin_select_6,
    input wire logic        analog_pin_select_7,
    input wire logic [3:0]  input_route,
    input wire logic        sample_hold,
    input wire logic        conv_clock_active,
    input wire logic        conv_busy,
    input wire logic        irq,
    input wire logic [23:0] irq_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wr_ok;
    logic       st_ok;
    logic [3:0] pins_q;
    logic [2:0] sel_q;
    logic       gate_q;
    logic       en_q;
    logic [1:0] prio_q;
    logic [1:0] chan_q;
    logic [7:0] age_q;
    logic [7:0] gap_q;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign st_ok = wr_ok && avs_address == OFS_START && avs_writedata[START_BIT] && !conv_busy;
    // shadow copies of the settings, so checks need no view of the bodies
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pins_q <= '0;
            sel_q <= '0;
            gate_q <= 1'b0;
            en_q <= 1'b0;
            prio_q <= '0;
            chan_q <= '0;
            age_q <= '0;
            gap_q <= '0;
        end else if (ce) begin
            if (wr_ok && avs_address == OFS_PINS) pins_q <= avs_writedata[PIN_SEL_LSB +: 4];
            if (wr_ok && avs_address == OFS_MASK) en_q <= avs_writedata[0];
            if (wr_ok && avs_address == OFS_PRIO) prio_q <= avs_writedata[1:0];
            if (st_ok) chan_q <= avs_writedata[1:0];
            if (wr_ok && avs_address == OFS_CLOCK) begin
                sel_q <= avs_writedata[CLK_SEL_LSB +: SEL_W];
                gate_q <= avs_writedata[CLK_GATE_BIT];
                age_q <= '0;
            end else if (age_q != 8'hff) begin
                age_q <= age_q + 8'h01;
            end
            gap_q <= conv_clock_active ? 8'h01 : gap_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_start;
        st_ok;
    endsequence
    sequence s_gate_off;
        (!gate_q) [*3];
    endsequence
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
    a_idle_data: assert property (avs_waitrequest |-> avs_readdata == '0)
        else $error("read data not zero when idle");
    a_pin_follow: assert property ({analog_pin_select_7, analog_pin_select_6,
        analog_pin_select_5, analog_pin_select_4} == pins_q) else $error("pin select wrong");
    a_tick_period: assert property (conv_clock_active && gate_q && sel_q != 3'h7
        && age_q > 8'hc8 |-> gap_q == (8'h01 << sel_q)) else $error("tick period wrong");
    a_gate_stops: assert property (s_gate_off |-> !conv_clock_active)
        else $error("tick while gated off");
    a_route_latch: assert property (s_start |-> ##[1:6] input_route == (4'h1 << chan_q))
        else $error("route not latched");
    a_route_stable: assert property (conv_busy && $past(conv_busy) |-> $stable(input_route))
        else $error("route moved mid conversion");
    a_sample_delay: assert property (s_start |=> !sample_hold [*3] ##[1:600] sample_hold)
        else $error("sample phase timing wrong");
    a_irq_cause: assert property (irq |-> $past(en_q && prio_q > {cpu_irq_mask_bit1,
        cpu_irq_mask_bit0})) else $error("irq without enable or priority");
    a_vector_fixed: assert property (irq_vector == 24'h00_0024)
        else $error("vector wrong");
endmodule : cvc_chk
bind cvc_top cvc_chk u_chk (.*);
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top
    import cvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             low_osc = 1'b0;
    logic [4:0]       avs_address = '0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = '0;
    logic [3:0]       avs_byteenable = 4'hf;
    logic [1:0]       cpu_lvl = '0;
    logic             slow = 1'b0;
    logic             ce = 1'b1;
    logic [RES_W-1:0] lvl [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h155};
    logic [4:0]       offs [9] = '{OFS_CLOCK, OFS_PINS, OFS_START, OFS_RESULT, OFS_STATUS,
                                   OFS_MASK, OFS_PRIO, OFS_VECTOR, 5'h03};
    logic [3:0]       pin_pat [3] = '{4'h5, 4'ha, 4'hf};
    logic [31:0]      avs_readdata;
    logic [31:0]      rd;
    logic             avs_waitrequest, comp, irq, sh, cca, busy;
    logic [3:0]       pins, route;
    logic [9:0]       dac;
    logic [23:0]      vec;
    int               fails = 0;
    int               n_checks = 0;
    always #20 clk = ~clk;
    // free-running slow oscillator, phase unrelated to clk
    always #163 low_osc = ~low_osc;
    cvc_top DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .low_speed_osc(low_osc),
        .cpu_irq_mask_bit0(cpu_lvl[0]), .cpu_irq_mask_bit1(cpu_lvl[1]), .comparator_in(comp),
        .analog_pin_select_4(pins[0]), .analog_pin_select_5(pins[1]),
        .analog_pin_select_6(pins[2]), .analog_pin_select_7(pins[3]), .input_route(route),
        .sample_hold(sh), .dac_code(dac), .conv_clock_active(cca), .conv_busy(busy),
        .irq(irq), .irq_vector(vec));
    cvc_analog_src u_src (.clk(clk), .slow(slow), .lvl(lvl), .pin_analog(pins),
        .input_route(route), .sample_hold(sh), .dac_code(dac), .comparator_in(comp));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk("waitrequest", avs_waitrequest, 0);
    endtask : bus
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(0, OFS_STATUS, 0);
            n++;
        end while (rd[DONE_BIT] !== 1'b1 && n < 400);
    endtask : wait_done
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        #(40 * 20000);
        fails++;
        final_report();
    end
    initial begin
        int s;
        int cnt;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        chk("vector", vec, 24'h00_0024);
        foreach (offs[i]) begin
            bus(0, offs[i], 0);
            chk("reset read", rd, offs[i] == OFS_VECTOR ? 32'h24 : 32'h0);
        end
        // all four pins end up analog before any conversion
        foreach (pin_pat[i]) begin
            bus(1, OFS_PINS, 32'({pin_pat[i], 4'h0}));
            bus(0, OFS_PINS, 0);
            chk("pins read", rd, 32'({pin_pat[i], 4'h0}));
            chk("pin outputs", pins, pin_pat[i]);
        end
        avs_byteenable <= 4'he;
        bus(1, OFS_PINS, 0);
        avs_byteenable <= 4'hf;
        @(posedge clk);
        chk("lane refused", pins, 4'hf);
        for (s = 0; s < 8; s++) begin
            bus(1, OFS_CLOCK, 32'(8 + s));
            repeat (210) @(posedge clk);
            cnt = 0;
            repeat (128) begin
                @(posedge clk);
                cnt += int'(cca === 1'b1);
            end
            if (s < 7) chk("ticks", 32'(cnt), 32'(128 >> s));
            else chk("slow ticks", 32'(cnt >= 14 && cnt <= 17), 1);
        end
        bus(1, OFS_CLOCK, 0);
        repeat (5) @(posedge clk);
        cnt = 0;
        repeat (64) begin
            @(posedge clk);
            cnt += int'(cca !== 1'b0);
        end
        chk("gated ticks", 32'(cnt), 0);
        bus(1, OFS_CLOCK, 32'h8);
        bus(1, OFS_MASK, 1);
        bus(1, OFS_PRIO, 3);
        for (s = 0; s < 4; s++) begin
            slow <= s[0];
            // the registered slow comparator needs ticks spaced wider than the settle time
            bus(1, OFS_CLOCK, s[0] ? 32'hb : 32'h8);
            bus(1, OFS_START, 32'h80 + 32'(s));
            wait_done();
            chk("done", rd, 1);
            chk("irq", irq, 1);
            bus(0, OFS_RESULT, 0);
            chk("result", rd, 32'(lvl[s]));
            bus(0, OFS_START, 0);
            chk("start reads", rd, 32'(s));
            bus(1, OFS_STATUS, 0);
            bus(0, OFS_STATUS, 0);
            chk("done kept", rd, 1);
            bus(1, OFS_STATUS, 1);
            bus(0, OFS_STATUS, 0);
            chk("done cleared", rd, 0);
            chk("irq cleared", irq, 0);
        end
        bus(1, OFS_MASK, 0);
        bus(1, OFS_START, 32'h81);
        wait_done();
        chk("done masked", rd, 1);
        chk("irq masked", irq, 0);
        cpu_lvl <= 2'h1;
        bus(1, OFS_PRIO, 1);
        bus(1, OFS_MASK, 1);
        repeat (3) @(posedge clk);
        chk("irq equal level", irq, 0);
        cpu_lvl <= 2'h0;
        repeat (3) @(posedge clk);
        chk("irq above level", irq, 1);
        bus(1, OFS_STATUS, 1);
        bus(1, OFS_START, 32'h82);
        repeat (8) @(posedge clk);
        bus(0, OFS_RESULT, 0);
        chk("result held", rd, 32'(lvl[1]));
        chk("busy", busy, 1);
        bus(1, OFS_START, 32'h83);
        wait_done();
        bus(0, OFS_RESULT, 0);
        chk("busy start dropped", rd, 32'(lvl[2]));
        chk("route", route, 4'h4);
        chk("dac final", 32'(dac), 32'(lvl[2]));
        chk("busy idle", busy, 0);
        bus(1, OFS_STATUS, 1);
        bus(1, OFS_START, 32'h3);
        repeat (100) @(posedge clk);
        bus(0, OFS_STATUS, 0);
        chk("no start on zero", rd, 0);
        // with ce low the divider stands still, so cca keeps its frozen level
        ce <= 1'b0;
        @(posedge clk);
        cnt = 0;
        repeat (40) begin
            @(posedge clk);
            cnt += int'(cca === 1'b1);
        end
        ce <= 1'b1;
        chk("frozen ticks", 32'(cnt % 40), 0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
